// ---- mpwm_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "mpwm_regs.svh"
// Operation
// RULE_01 - Carrier is a sixteen-bit up/down counter.
// RULE_02 - Counter advances one count per system clock normally.
// RULE_03 - Mode 0 edge-aligned sawtooth, mode 1 center-aligned triangle.
// RULE_04 - Period extension set: counter advances once every four clocks.
// RULE_05 - Period value double-buffered, refreshed per period or half period.
// RULE_06 - Each phase output follows compare value versus counter.
// RULE_07 - Compare working copies load at period match, optionally half period.
// RULE_08 - All phases share one carrier frequency.
// RULE_09 - Independent mode: each phase uses its own compare value.
// RULE_10 - Common mode: U compare drives all three phases.
// RULE_11 - PWM interrupt every half, one, two or four periods.
// RULE_12 - Enable bit zero puts all six outputs in high impedance.
// RULE_13 - Emergency stop forces outputs per two-bit action field.
// RULE_14 - Software keeps load source at bus mode zero.
// RULE_15 - Software writes sixteen-bit registers as whole halfwords.
// RULE_16 - Output-level bits double-buffered, sync or async to PWM.
// RULE_17 - Output-control bits 10..8 pick PWM or fixed level per phase.
// RULE_18 - Upper and lower polarity set independently; 1 active high.
// RULE_19 - Software changes polarity only while enable bit is zero.
// RULE_20 - Single-shunt center-off set by software via compare and output field.
// RULE_21 - ADC trigger on counter match with trigger compare, gated by enable.
// RULE_22 - Center mode counts up to period then down, reversing at ends.
module mpwm_top
(
	input  wire logic                     clk_sys_i,
	input  wire logic                     rst_b_i,
	input  wire logic [`MPWM_ADDR_W-1:0]  addr_i,
	input  wire logic [31:0]              wdata_i,
	input  wire logic                     wr_i,
	input  wire logic                     rd_i,
	output logic      [31:0]              rdata_o,
	input  wire logic                     emergency_stop_input_b_i,
	output mpwm_pkg::mpwm_gate_t          gate_o,
	output mpwm_pkg::mpwm_gate_t          gate_oe_o,
	output logic                          pwm_irq_o,
	output logic                          adc_start_trigger_o
);
	// ----------------------------------------
	// Register file
	// ----------------------------------------
	logic        pwm_output_enable_q, pwm_output_enable_d;
	logic        port_output_mode_q, port_output_mode_d;
	logic        buffer_load_source_q, buffer_load_source_d;
	logic [15:0] ctrl_q, ctrl_d;
	logic [15:0] period_q, period_d;
	logic [15:0] cmp_q [3];
	logic [15:0] cmp_d [3];
	logic [15:0] outctl_q, outctl_d;
	logic [15:0] outset_q, outset_d;
	logic [1:0]  emergency_output_action_q, emergency_output_action_d;
	logic [15:0] trigger_compare_value_q, trigger_compare_value_d;
	logic [31:0] rdata_q, rdata_d;
	logic [15:0] carrier_counter_q;
	logic        emg_active_q;

	always_comb
	begin
		pwm_output_enable_d       = pwm_output_enable_q;
		port_output_mode_d        = port_output_mode_q;
		buffer_load_source_d      = buffer_load_source_q;
		ctrl_d                    = ctrl_q;
		period_d                  = period_q;
		cmp_d                     = cmp_q;
		outctl_d                  = outctl_q;
		outset_d                  = outset_q;
		emergency_output_action_d = emergency_output_action_q;
		trigger_compare_value_d   = trigger_compare_value_q;
		rdata_d                   = 32'h0000_0000;
		if (wr_i)
		begin
			unique case (addr_i)
				`MPWM_OFF_ENABLE:  pwm_output_enable_d = wdata_i[0];
				`MPWM_OFF_PORTMD:  port_output_mode_d = wdata_i[0];
				`MPWM_OFF_MODESEL: buffer_load_source_d = wdata_i[0];
				`MPWM_OFF_CTRL:    ctrl_d = {9'h000, wdata_i[6:0]};
				// Whole-halfword writes only; byte writes are not supported.
				`MPWM_OFF_PERIOD:  period_d = wdata_i[15:0]; // RULE_15
				`MPWM_OFF_CMPU:    cmp_d[0] = wdata_i[15:0];
				`MPWM_OFF_CMPV:    cmp_d[1] = wdata_i[15:0];
				`MPWM_OFF_CMPW:    cmp_d[2] = wdata_i[15:0];
				`MPWM_OFF_OUTCTL:  outctl_d = {5'h00, wdata_i[10:8], 2'h0, wdata_i[5:0]};
				`MPWM_OFF_OUTSET:  outset_d = {12'h000, wdata_i[3:2], 2'h0};
				`MPWM_OFF_EMG:     emergency_output_action_d = wdata_i[1:0];
				`MPWM_OFF_TRIGGER_COMPARE_VALUE:  trigger_compare_value_d = wdata_i[15:0];
				default: ;
			endcase
		end
		if (rd_i)
		begin
			unique case (addr_i)
				`MPWM_OFF_ENABLE:  rdata_d = {31'h0, pwm_output_enable_q};
				`MPWM_OFF_PORTMD:  rdata_d = {31'h0, port_output_mode_q};
				`MPWM_OFF_MODESEL: rdata_d = {31'h0, buffer_load_source_q};
				`MPWM_OFF_CTRL:    rdata_d = {16'h0, ctrl_q};
				`MPWM_OFF_COUNT:   rdata_d = {16'h0, carrier_counter_q};
				`MPWM_OFF_PERIOD:  rdata_d = {16'h0, period_q};
				`MPWM_OFF_CMPU:    rdata_d = {16'h0, cmp_q[0]};
				`MPWM_OFF_CMPV:    rdata_d = {16'h0, cmp_q[1]};
				`MPWM_OFF_CMPW:    rdata_d = {16'h0, cmp_q[2]};
				`MPWM_OFF_OUTCTL:  rdata_d = {16'h0, outctl_q};
				`MPWM_OFF_OUTSET:  rdata_d = {16'h0, outset_q};
				`MPWM_OFF_EMG:     rdata_d = {29'h0, emg_active_q, emergency_output_action_q};
				`MPWM_OFF_TRIGGER_COMPARE_VALUE:  rdata_d = {16'h0, trigger_compare_value_q};
				default:           rdata_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_b_i)
		begin
			pwm_output_enable_q       <= 1'b0;
			port_output_mode_q        <= 1'b0;
			buffer_load_source_q      <= 1'b0;
			ctrl_q                    <= `MPWM_CTRL_RST;
			period_q                  <= `MPWM_PERIOD_RST;
			cmp_q                     <= '{16'h0000, 16'h0000, 16'h0000};
			outctl_q                  <= `MPWM_OUTCTL_RST;
			outset_q                  <= `MPWM_OUTSET_RST;
			emergency_output_action_q <= 2'h0;
			trigger_compare_value_q   <= 16'h0000;
			rdata_q                   <= 32'h0000_0000;
		end
		else
		begin
			pwm_output_enable_q       <= pwm_output_enable_d;
			port_output_mode_q        <= port_output_mode_d;
			buffer_load_source_q      <= buffer_load_source_d;
			ctrl_q                    <= ctrl_d;
			period_q                  <= period_d;
			cmp_q                     <= cmp_d;
			outctl_q                  <= outctl_d;
			outset_q                  <= outset_d;
			emergency_output_action_q <= emergency_output_action_d;
			trigger_compare_value_q   <= trigger_compare_value_d;
			rdata_q                   <= rdata_d;
		end
	end

	assign rdata_o = rdata_q;

	// ----------------------------------------
	// Carrier counter
	// ----------------------------------------
	wire       center_mode = ctrl_q[`MPWM_CTRL_MODE_BIT];
	wire       half_load   = ctrl_q[`MPWM_CTRL_HALF_BIT];
	wire       common_mode = ctrl_q[`MPWM_CTRL_COMMON_BIT];
	wire       period_ext  = ctrl_q[`MPWM_CTRL_EXT_BIT];
	wire       sync_out    = ctrl_q[`MPWM_CTRL_SYNC_BIT];
	wire [1:0] intp        = ctrl_q[`MPWM_CTRL_INTP_LSB +: 2];

	logic [1:0]  prescale_q, prescale_d;
	logic [15:0] carrier_counter_d;
	logic        count_down_q, count_down_d;
	logic [15:0] period_act_q, period_act_d;
	logic [15:0] cmp_act_q [3];
	logic [15:0] cmp_act_d [3];
	logic [1:0]  int_cnt_q, int_cnt_d;
	logic        irq_q, irq_d;
	logic        trig_q, trig_d;
	logic        tick, at_period, at_half, load_pt, full_pt;

	always_comb
	begin
		prescale_d        = prescale_q;
		carrier_counter_d = carrier_counter_q;
		count_down_d      = count_down_q;
		period_act_d      = period_act_q;
		cmp_act_d         = cmp_act_q;
		int_cnt_d         = int_cnt_q;
		irq_d             = 1'b0;
		trig_d            = 1'b0;
		// Extension mode slows the step to one count per four clocks
		tick      = !period_ext || (prescale_q == `MPWM_EXT_DIV); // RULE_02 RULE_04
		at_period = carrier_counter_q == period_act_q;
		// Half-period point: bottom of triangle, or midpoint of sawtooth
		at_half   = center_mode ? (carrier_counter_q == 16'h0001 && count_down_q)
			: (carrier_counter_q == {1'b0, period_act_q[15:1]});
		full_pt   = at_period;
		load_pt   = at_period || (half_load && at_half);
		if (!pwm_output_enable_q)
		begin
			prescale_d        = 2'h0;
			carrier_counter_d = 16'h0000;
			count_down_d      = 1'b0;
			int_cnt_d         = 2'h0;
			period_act_d      = period_q;
			cmp_act_d         = cmp_q;
		end
		else if (tick)
		begin
			prescale_d = 2'(prescale_q + 2'h1);
			if (center_mode) // RULE_03
			begin
				if (!count_down_q && carrier_counter_q >= period_act_q) // RULE_22
				begin
					count_down_d      = 1'b1;
					carrier_counter_d = 16'(carrier_counter_q - 16'h0001);
				end
				else if (count_down_q && carrier_counter_q <= 16'h0001)
				begin
					count_down_d      = 1'b0;
					carrier_counter_d = 16'h0000;
				end
				else
					carrier_counter_d = count_down_q ? 16'(carrier_counter_q - 16'h0001)
						: 16'(carrier_counter_q + 16'h0001); // RULE_01
			end
			else
			begin
				count_down_d      = 1'b0;
				carrier_counter_d = at_period ? 16'h0000 : 16'(carrier_counter_q + 16'h0001);
			end
			if (load_pt) // RULE_05 RULE_07
			begin
				period_act_d = period_q;
				if (!buffer_load_source_q) // RULE_14
					cmp_act_d = cmp_q;
			end
			if (full_pt || (intp == mpwm_pkg::MPWM_INT_HALF && at_half)) // RULE_11
			begin
				int_cnt_d = 2'(int_cnt_q + 2'h1);
				unique case (intp)
					mpwm_pkg::MPWM_INT_HALF,
					mpwm_pkg::MPWM_INT_ONE:  irq_d = 1'b1;
					mpwm_pkg::MPWM_INT_TWO:  irq_d = int_cnt_q[0];
					mpwm_pkg::MPWM_INT_FOUR: irq_d = &int_cnt_q;
				endcase
			end
			// Edge mode matches only on the up-count, the only direction it has
			trig_d = carrier_counter_q == trigger_compare_value_q; // RULE_21
		end
		else
			prescale_d = 2'(prescale_q + 2'h1);
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_b_i)
		begin
			prescale_q        <= 2'h0;
			carrier_counter_q <= 16'h0000;
			count_down_q      <= 1'b0;
			period_act_q      <= `MPWM_PERIOD_RST;
			cmp_act_q         <= '{16'h0000, 16'h0000, 16'h0000};
			int_cnt_q         <= 2'h0;
			irq_q             <= 1'b0;
			trig_q            <= 1'b0;
		end
		else
		begin
			prescale_q        <= prescale_d;
			carrier_counter_q <= carrier_counter_d;
			count_down_q      <= count_down_d;
			period_act_q      <= period_act_d;
			cmp_act_q         <= cmp_act_d;
			int_cnt_q         <= int_cnt_d;
			irq_q             <= irq_d;
			trig_q            <= trig_d;
		end
	end

	assign pwm_irq_o           = irq_q;
	assign adc_start_trigger_o = trig_q && pwm_output_enable_q; // RULE_21

	// ----------------------------------------
	// Conduction control and port drive
	// ----------------------------------------
	logic [15:0]          outctl_act_q, outctl_act_d;
	logic                 emg_active_d;
	mpwm_pkg::mpwm_gate_t gate_q, gate_d, oe_q, oe_d;
	logic [2:0]           pwm_raw;

	genvar ph;
	generate
		for (ph = 0; ph < 3; ph++)
		begin : g_phase
			// Common mode lets the U compare drive every phase
			wire [15:0] cmp_sel = common_mode ? cmp_act_q[0] : cmp_act_q[ph]; // RULE_08 RULE_09 RULE_10
			assign pwm_raw[ph] = cmp_sel > carrier_counter_q; // RULE_06
		end
	endgenerate

	always_comb
	begin
		// Async update copies at once; sync waits for the PWM load point
		outctl_act_d = (!sync_out || (tick && load_pt) || !pwm_output_enable_q)
			? outctl_q : outctl_act_q; // RULE_16
		emg_active_d = emg_active_q;
		if (!emergency_stop_input_b_i)
			emg_active_d = 1'b1;
		else if (outctl_q[10:8] == 3'h0 && outctl_q[5:0] == 6'h00)
			emg_active_d = 1'b0;
		for (int i = 0; i < 3; i++)
		begin
			// Bits 10..8 choose PWM; else bits [2i+1:2i] give upper/lower level
			if (outctl_act_q[8 + i]) // RULE_17
			begin
				gate_d.hi[i] = outctl_act_q[2*i+1] & pwm_raw[i];
				gate_d.lo[i] = outctl_act_q[2*i] & ~pwm_raw[i];
			end
			else
			begin
				gate_d.hi[i] = outctl_act_q[2*i+1];
				gate_d.lo[i] = outctl_act_q[2*i];
			end
			// Active-low polarity inverts the asserted level
			gate_d.hi[i] = gate_d.hi[i] ~^ outset_q[`MPWM_OUTSET_UPPER_SIDE_POLARITY_BIT]; // RULE_18
			gate_d.lo[i] = gate_d.lo[i] ~^ outset_q[`MPWM_OUTSET_POLL_BIT]; // RULE_18
		end
		oe_d.hi = {3{pwm_output_enable_q}}; // RULE_12
		oe_d.lo = {3{pwm_output_enable_q}}; // RULE_12
		if (emg_active_q && !port_output_mode_q)
		begin
			unique case (emergency_output_action_q) // RULE_13
				mpwm_pkg::MPWM_EMG_HIZ_ALL:
				begin
					oe_d.hi = 3'h0;
					oe_d.lo = 3'h0;
				end
				mpwm_pkg::MPWM_EMG_HIZ_HI: oe_d.hi = 3'h0;
				mpwm_pkg::MPWM_EMG_HIZ_LO: oe_d.lo = 3'h0;
				mpwm_pkg::MPWM_EMG_HOLD:
				begin
					gate_d.hi = {3{~outset_q[`MPWM_OUTSET_UPPER_SIDE_POLARITY_BIT]}};
					gate_d.lo = {3{~outset_q[`MPWM_OUTSET_POLL_BIT]}};
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_b_i)
		begin
			outctl_act_q <= `MPWM_OUTCTL_RST;
			emg_active_q <= 1'b0;
			gate_q       <= '0;
			oe_q         <= '0;
		end
		else
		begin
			outctl_act_q <= outctl_act_d;
			emg_active_q <= emg_active_d;
			gate_q       <= gate_d;
			oe_q         <= oe_d;
		end
	end

	assign gate_o    = gate_q;
	assign gate_oe_o = oe_q;
endmodule
`default_nettype wire

// ---- mpwm_regs.svh ----
`ifndef MPWM_REGS_SVH
`define MPWM_REGS_SVH
`define MPWM_ADDR_W         6
`define MPWM_OFF_ENABLE     6'h00
`define MPWM_OFF_PORTMD     6'h04
`define MPWM_OFF_MODESEL    6'h08
`define MPWM_OFF_CTRL       6'h0C
`define MPWM_OFF_COUNT      6'h10
`define MPWM_OFF_PERIOD     6'h14
`define MPWM_OFF_CMPU       6'h18
`define MPWM_OFF_CMPV       6'h1C
`define MPWM_OFF_CMPW       6'h20
`define MPWM_OFF_OUTCTL     6'h24
`define MPWM_OFF_OUTSET     6'h28
`define MPWM_OFF_EMG        6'h2C
`define MPWM_OFF_TRIGGER_COMPARE_VALUE     6'h30
`define MPWM_CTRL_MODE_BIT  0
`define MPWM_CTRL_INTP_LSB  1
`define MPWM_CTRL_HALF_BIT  3
`define MPWM_CTRL_COMMON_BIT 4
`define MPWM_CTRL_EXT_BIT   5
`define MPWM_CTRL_SYNC_BIT  6
`define MPWM_CTRL_RST       16'h0000
`define MPWM_PERIOD_RST     16'hFFFF
`define MPWM_OUTCTL_RST     16'h0000
`define MPWM_OUTSET_RST     16'h000C
`define MPWM_OUTSET_POLL_BIT 2
`define MPWM_OUTSET_UPPER_SIDE_POLARITY_BIT 3
`define MPWM_EXT_DIV        2'h3
`endif

// ---- mpwm_pkg.sv ----
`default_nettype none
package mpwm_pkg;
	typedef struct packed {
		logic [2:0] hi;
		logic [2:0] lo;
	} mpwm_gate_t;
	typedef enum logic [1:0] {
		MPWM_INT_HALF = 2'b00,
		MPWM_INT_ONE  = 2'b01,
		MPWM_INT_TWO  = 2'b10,
		MPWM_INT_FOUR = 2'b11
	} mpwm_intp_t;
	typedef enum logic [1:0] {
		MPWM_EMG_HIZ_ALL = 2'b00,
		MPWM_EMG_HIZ_HI  = 2'b01,
		MPWM_EMG_HIZ_LO  = 2'b10,
		MPWM_EMG_HOLD    = 2'b11
	} mpwm_emg_t;
endpackage
`default_nettype wire

// ---- mpwm_drv_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------
// Gate driver inputs of the inverter legs
// ------------------------------------------
module mpwm_drv_model
(
	input  wire mpwm_pkg::mpwm_gate_t gate_i,
	input  wire mpwm_pkg::mpwm_gate_t oe_i,
	output logic [5:0]                pin_o
);
	// Driver inputs carry pull-downs, so a released line reads low, never its last level
	assign pin_o = gate_i & oe_i;
endmodule
`default_nettype wire

// ---- mpwm_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "mpwm_regs.svh"
module mpwm_checker
(
	input wire logic                    clk_sys_i,
	input wire logic                    rst_b_i,
	input wire logic [`MPWM_ADDR_W-1:0] addr_i,
	input wire logic [31:0]             wdata_i,
	input wire logic                    wr_i,
	input wire logic                    rd_i,
	input wire logic [31:0]             rdata_o,
	input wire logic                    emergency_stop_input_b_i,
	input wire mpwm_pkg::mpwm_gate_t    gate_o,
	input wire mpwm_pkg::mpwm_gate_t    gate_oe_o,
	input wire logic                    pwm_irq_o,
	input wire logic                    adc_start_trigger_o
);
	// ------------------------------------------
	// Mirrors of the registers the rules depend on
	// ------------------------------------------
	logic        en_q;
	logic        en_d;
	logic [1:0]  act_q;
	logic [1:0]  act_d;
	logic [6:0]  ctl_q;
	logic [6:0]  ctl_d;
	logic [15:0] per_q;
	logic [15:0] per_d;
	logic        emg_on;
	always_comb
	begin
		en_d = en_q;
		act_d = act_q;
		ctl_d = ctl_q;
		per_d = per_q;
		if (wr_i)
		begin
			case (addr_i)
				`MPWM_OFF_ENABLE: en_d = wdata_i[0];
				`MPWM_OFF_EMG: act_d = wdata_i[1:0];
				`MPWM_OFF_CTRL: ctl_d = wdata_i[6:0];
				`MPWM_OFF_PERIOD: per_d = wdata_i[15:0];
				default: ;
			endcase
		end
	end
	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_b_i)
		begin
			en_q <= 1'h0;
			act_q <= 2'h0;
			ctl_q <= 7'h00;
			per_q <= 16'hFFFF;
		end
		else
		begin
			en_q <= en_d;
			act_q <= act_d;
			ctl_q <= ctl_d;
			per_q <= per_d;
		end
	end
	assign emg_on = !emergency_stop_input_b_i && en_q;
	// ------------------------------------------
	// Properties
	// ------------------------------------------
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_b_i);
	hiz_off_a: assert property (!en_q && $past(!en_q) |-> gate_oe_o == 6'h00)
		else $error("gate outputs driven while disabled");
	trig_gated_a: assert property (!en_q && $past(!en_q) |-> !adc_start_trigger_o)
		else $error("trigger while disabled");
	irq_pulse_a: assert property (pwm_irq_o |=> !pwm_irq_o)
		else $error("interrupt pulse longer than one cycle");
	emg_hiz_a: assert property (emg_on && act_q == 2'h0 |-> ##[1:3] gate_oe_o == 6'h00)
		else $error("emergency did not release all gates");
	emg_hi_a: assert property (emg_on && act_q == 2'h1 |-> ##[1:3] gate_oe_o.hi == 3'h0)
		else $error("emergency did not release upper gates");
	mode_rd_a: assert property ($past(rd_i && addr_i == `MPWM_OFF_CTRL) |->
		rdata_o[6:0] == $past(ctl_q))
		else $error("control readback differs");
	cnt_range_a: assert property ($past(rd_i && addr_i == `MPWM_OFF_COUNT) |->
		rdata_o[15:0] <= $past(per_q))
		else $error("counter beyond period");
	cnt_hold_a: assert property ($past(rd_i && addr_i == `MPWM_OFF_COUNT && !en_q)
		&& $past(!en_q, 2) |-> rdata_o[15:0] == 16'h0000)
		else $error("counter runs while disabled");
endmodule
bind mpwm_top mpwm_checker chk_u (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
	.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
	.emergency_stop_input_b_i(emergency_stop_input_b_i), .gate_o(gate_o),
	.gate_oe_o(gate_oe_o), .pwm_irq_o(pwm_irq_o), .adc_start_trigger_o(adc_start_trigger_o));
`default_nettype wire

// ---- tb_three_phase_motor_pwm_generator.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "mpwm_regs.svh"
module tb_three_phase_motor_pwm_generator;
	logic                 clk_sys_i = 1'h0;
	logic                 rst_b_i = 1'h0;
	logic [5:0]           addr_i = 6'h00;
	logic [31:0]          wdata_i = 32'h0;
	logic                 wr_i = 1'h0;
	logic                 rd_i = 1'h0;
	logic                 emg_b = 1'h1;
	logic [31:0]          rdata_o;
	mpwm_pkg::mpwm_gate_t gate_o;
	mpwm_pkg::mpwm_gate_t gate_oe_o;
	logic                 irq;
	logic                 trg;
	logic [5:0]           pin;
	int                   errors = 0;
	int                   check_count = 0;
	int                   pc [6];
	int                   ic;
	int                   tc;
	logic [15:0]          cap [16];
	logic [31:0]          v;
	mpwm_top dut_u (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.emergency_stop_input_b_i(emg_b), .gate_o(gate_o), .gate_oe_o(gate_oe_o),
		.pwm_irq_o(irq), .adc_start_trigger_o(trg));
	mpwm_drv_model drv_u (.gate_i(gate_o), .oe_i(gate_oe_o), .pin_o(pin));
	always #5 clk_sys_i = ~clk_sys_i;
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e)
		begin
			errors++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'h1;
		@(posedge clk_sys_i);
		wr_i <= 1'h0;
		@(posedge clk_sys_i);
	endtask
	// Back-to-back reads: read data of each stands only in the following cycle
	task automatic rdn(input logic [5:0] a, input int n);
		addr_i <= a;
		rd_i <= 1'h1;
		for (int i = 0; i < n; i++)
		begin
			@(posedge clk_sys_i);
			if (i == n - 1)
				rd_i <= 1'h0;
			#1;
			cap[i] = rdata_o[15:0];
			v = rdata_o;
		end
		@(posedge clk_sys_i);
	endtask
	task automatic watch(input int n);
		pc = '{default: 0};
		ic = 0;
		tc = 0;
		repeat (n)
		begin
			@(posedge clk_sys_i);
			#1;
			for (int j = 0; j < 6; j++)
				pc[j] += pin[j];
			ic += irq;
			tc += trg;
		end
		@(posedge clk_sys_i);
	endtask
	task automatic run(input logic [15:0] u, vv, w, oc, ct, po);
		wr(`MPWM_OFF_CMPU, {16'h0, u});
		wr(`MPWM_OFF_CMPV, {16'h0, vv});
		wr(`MPWM_OFF_CMPW, {16'h0, w});
		wr(`MPWM_OFF_OUTCTL, {16'h0, oc});
		wr(`MPWM_OFF_CTRL, {16'h0, ct});
		wr(`MPWM_OFF_OUTSET, {16'h0, po});
		wr(`MPWM_OFF_ENABLE, 32'h1);
		repeat (4) @(posedge clk_sys_i);
		watch(100);
		wr(`MPWM_OFF_ENABLE, 32'h0);
		@(posedge clk_sys_i);
		chk("oe_off", 32'h0, gate_oe_o);
	endtask
	task automatic t_regs;
		rdn(`MPWM_OFF_PERIOD, 1);
		chk("period_rst", 32'hFFFF, v);
		rdn(`MPWM_OFF_OUTSET, 1);
		chk("pol_rst", 32'hC, v);
		rdn(6'h3C, 1);
		chk("unmapped", 32'h0, v);
		wr(`MPWM_OFF_CTRL, 32'h5B);
		rdn(`MPWM_OFF_CTRL, 1);
		chk("ctrl_rd", 32'h5B, v);
		$display("test regs done");
	endtask
	task automatic t_count;
		wr(`MPWM_OFF_PERIOD, 32'h5);
		wr(`MPWM_OFF_CTRL, 32'h0);
		wr(`MPWM_OFF_ENABLE, 32'h1);
		rdn(`MPWM_OFF_COUNT, 12);
		chk("cnt_known", 32'h1, cap[0] <= 16'h5);
		for (int i = 0; i < 11; i++)
			chk("edge_step", (cap[i] + 16'h1) % 16'h6, cap[i + 1]);
		wr(`MPWM_OFF_ENABLE, 32'h0);
		wr(`MPWM_OFF_CTRL, 32'h1);
		wr(`MPWM_OFF_ENABLE, 32'h1);
		rdn(`MPWM_OFF_COUNT, 12);
		for (int i = 0; i < 11; i++)
			chk("tri_step", 32'h1, cap[i + 1] - cap[i] == 16'h1 || cap[i] - cap[i + 1] == 16'h1);
		wr(`MPWM_OFF_ENABLE, 32'h0);
		wr(`MPWM_OFF_PERIOD, 32'hC8);
		wr(`MPWM_OFF_CTRL, 32'h20);
		wr(`MPWM_OFF_ENABLE, 32'h1);
		rdn(`MPWM_OFF_COUNT, 13);
		ic = 0;
		for (int i = 0; i < 12; i++)
			ic += (cap[i] != cap[i + 1]);
		chk("ext_steps", 32'h3, ic);
		wr(`MPWM_OFF_ENABLE, 32'h0);
		rdn(`MPWM_OFF_COUNT, 1);
		chk("cnt_hold", 32'h0, v);
		$display("test count done");
	endtask
	task automatic t_duty;
		wr(`MPWM_OFF_MODESEL, 32'h0);
		wr(`MPWM_OFF_PORTMD, 32'h0);
		wr(`MPWM_OFF_PERIOD, 32'h63);
		run(16'h32, 16'h14, 16'h50, 16'h73F, 16'h0, 16'hC);
		chk("hi_u", 32'h32, pc[3]);
		chk("hi_v", 32'h14, pc[4]);
		chk("hi_w", 32'h50, pc[5]);
		chk("lo_v", 32'h50, pc[1]);
		run(16'h32, 16'h14, 16'h50, 16'h73F, 16'h10, 16'hC);
		chk("com_v", 32'h32, pc[4]);
		chk("com_w", 32'h32, pc[5]);
		run(16'h1E, 16'h14, 16'h50, 16'h73F, 16'h0, 16'h0);
		chk("neg_hi", 32'h46, pc[3]);
		chk("neg_lo", 32'h1E, pc[0]);
		run(16'h32, 16'h14, 16'h50, 16'h2, 16'h0, 16'hC);
		chk("fix_hi", 32'h64, pc[3]);
		chk("fix_off", 32'h0, pc[4]);
		run(16'h45, 16'h14, 16'h50, 16'h73C, 16'h0, 16'hC);
		chk("shunt_u", 32'h0, pc[3]);
		chk("shunt_v", 32'h14, pc[4]);
		$display("test duty done");
	endtask
	task automatic t_irq;
		wr(`MPWM_OFF_PERIOD, 32'h13);
		wr(`MPWM_OFF_TRIGGER_COMPARE_VALUE, 32'h7);
		for (int k = 0; k < 4; k++)
		begin
			wr(`MPWM_OFF_CTRL, k << 1);
			wr(`MPWM_OFF_ENABLE, 32'h1);
			repeat (4) @(posedge clk_sys_i);
			watch(160);
			wr(`MPWM_OFF_ENABLE, 32'h0);
			chk("irq_count", 32'h10 >> k, ic);
			chk("trg_count", 32'h8, tc);
		end
		$display("test irq done");
	endtask
	task automatic t_emg;
		logic [5:0] exp_oe [4];
		exp_oe = '{6'h00, 6'h07, 6'h38, 6'h3F};
		wr(`MPWM_OFF_PERIOD, 32'h63);
		for (int k = 0; k < 4; k++)
		begin
			wr(`MPWM_OFF_EMG, k);
			wr(`MPWM_OFF_OUTCTL, 32'h73F);
			wr(`MPWM_OFF_ENABLE, 32'h1);
			emg_b <= 1'h0;
			repeat (2) @(posedge clk_sys_i);
			emg_b <= 1'h1;
			repeat (4) @(posedge clk_sys_i);
			chk("emg_oe", exp_oe[k], gate_oe_o);
			rdn(`MPWM_OFF_EMG, 1);
			chk("emg_state", 32'h1, v[2]);
			wr(`MPWM_OFF_ENABLE, 32'h0);
			wr(`MPWM_OFF_OUTCTL, 32'h0);
			rdn(`MPWM_OFF_EMG, 1);
			chk("emg_clear", 32'h0, v[2]);
		end
		// Port mode set: the hold action must not touch fixed levels
		wr(`MPWM_OFF_PORTMD, 32'h1);
		wr(`MPWM_OFF_OUTCTL, 32'h3F);
		wr(`MPWM_OFF_ENABLE, 32'h1);
		emg_b <= 1'h0;
		repeat (2) @(posedge clk_sys_i);
		emg_b <= 1'h1;
		repeat (4) @(posedge clk_sys_i);
		chk("emg_ignored", 32'h3F, gate_o);
		wr(`MPWM_OFF_ENABLE, 32'h0);
		wr(`MPWM_OFF_OUTCTL, 32'h0);
		wr(`MPWM_OFF_PORTMD, 32'h0);
		$display("test emg done");
	endtask
	// Period far longer than the watch, so no load point falls inside it
	task automatic t_sync;
		wr(`MPWM_OFF_PERIOD, 32'h3E8);
		for (int k = 0; k < 2; k++)
		begin
			wr(`MPWM_OFF_CMPU, 32'h3E8);
			wr(`MPWM_OFF_CMPV, 32'h3E8);
			wr(`MPWM_OFF_OUTCTL, 32'h73F);
			wr(`MPWM_OFF_CTRL, k ? 32'h0 : 32'h40);
			wr(`MPWM_OFF_ENABLE, 32'h1);
			wr(`MPWM_OFF_OUTCTL, 32'h0);
			wr(`MPWM_OFF_CMPV, 32'h0);
			watch(20);
			chk("sync_hold", k ? 32'h0 : 32'h14, pc[3]);
			chk("cmp_hold", k ? 32'h0 : 32'h14, pc[4]);
			wr(`MPWM_OFF_ENABLE, 32'h0);
		end
		$display("test sync done");
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial
	begin
		repeat (12) @(posedge clk_sys_i);
		rst_b_i <= 1'h1;
		@(posedge clk_sys_i);
		t_regs();
		t_count();
		t_duty();
		t_irq();
		t_emg();
		t_sync();
		summarize();
	end
	// The whole sequence needs about 1600 cycles
	initial
	begin
		repeat (20000) @(posedge clk_sys_i);
		errors++;
		summarize();
	end
endmodule
`default_nettype wire
